// ===== rtl/fsqr_ctrl.sv
// Flash status, clear-status and query controller with an AHB-Lite register slave
`timescale 1ns/1ps
`include "fsqr_cfg.svh"
module fsqr_ctrl (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic [31:0]             hrdata,
  output logic                    hresp,
  // Flash pins
  input  wire logic [15:0]        dq_in,
  output fsqr_pkg::fsqr_pins_s    pins
);

  typedef enum logic [5:0] {
    FSQR_S_IDLE   = 6'b000001,
    FSQR_S_PRE    = 6'b000010,
    FSQR_S_PRE_RD = 6'b000100,
    FSQR_S_CMD    = 6'b001000,
    FSQR_S_RD     = 6'b010000,
    FSQR_S_DONE   = 6'b100000
  } fsqr_state_e;

  // Bus slave state
  logic                wr_pend, next_wr_pend;
  logic [7:0]          wr_addr, next_wr_addr;
  logic [31:0]         next_hrdata;

  // Software visible state
  logic [31:0]         ctrl, next_ctrl;
  logic [20:0]         addr, next_addr;
  logic [15:0]         wdata, next_wdata;
  logic [15:0]         rdata_q, next_rdata_q;
  logic [7:0]          flash_sr, next_flash_sr;
  logic                done_flag, next_done_flag;
  logic                refused, next_refused;
  logic                blk_valid, next_blk_valid;
  logic                blk_lock, next_blk_lock;
  logic                blk_efail, next_blk_efail;

  // Sequencer state
  fsqr_state_e         state, next_state;
  fsqr_pkg::fsqr_op_e  op, next_op;
  logic                start, next_start;
  fsqr_pkg::fsqr_req_s req, next_req;

  // Engine
  logic                eng_busy;
  logic                eng_done;
  logic [15:0]         eng_rdata;
  fsqr_pkg::fsqr_bus_s eng_bus;

  logic                byte_mode;
  logic                run;
  logic [7:0]          status_code;
  logic                addr_phase;
  logic                cmd_write;
  logic [20:0]         query_addr;
  logic [20:0]         block_addr;
  logic [7:0]          cmd_code;

  assign byte_mode   = ctrl[`FSQR_CTRL_BYTE];
  assign run         = ctrl[`FSQR_CTRL_RUN];
  assign status_code = ctrl[15:8];
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign addr_phase  = hsel & htrans[1] & hready;
  assign cmd_write   = wr_pend & (wr_addr == `FSQR_REG_CMD);

  // Word offset doubled onto the pins; A0 is don't-care to the device in byte mode
  assign query_addr  = {addr[19:0], 1'b0};
  assign block_addr  = {20'(addr + `FSQR_BLK_OFFSET), 1'b0};

  // Pins: strobes from the engine, mode and power-down from the control register
  assign pins = '{bus:               eng_bus,
                  byte_mode_n:       ~byte_mode,
                  reset_powerdown_n: run};

  // Command code for the write cycle of each operation
  always_comb begin
    case (op)
      fsqr_pkg::FSQR_OP_STATUS: cmd_code = status_code;
      fsqr_pkg::FSQR_OP_CLEAR:  cmd_code = `FSQR_CMD_CLEAR;
      fsqr_pkg::FSQR_OP_QUERY:  cmd_code = `FSQR_CMD_QUERY;
      fsqr_pkg::FSQR_OP_BLOCK:  cmd_code = `FSQR_CMD_QUERY;
      fsqr_pkg::FSQR_OP_EXT:    cmd_code = `FSQR_CMD_MULTI;
      default:                  cmd_code = wdata[7:0];
    endcase
  end

  // Register bus: write data phase and registered read data
  always_comb begin
    next_wr_pend = addr_phase & hwrite;
    next_wr_addr = addr_phase ? haddr[7:0] : wr_addr;
    next_hrdata  = hrdata;
    next_ctrl    = ctrl;
    next_addr    = addr;
    next_wdata   = wdata;
    if (addr_phase && !hwrite) begin
      case (haddr[7:0])
        `FSQR_REG_CMD:    next_hrdata = {29'h0000_0000, op};
        `FSQR_REG_ADDR:   next_hrdata = {11'h000, addr};
        `FSQR_REG_WDATA:  next_hrdata = {16'h0000, wdata};
        `FSQR_REG_RDATA:  next_hrdata = {16'h0000, rdata_q};
        `FSQR_REG_STATUS: next_hrdata = {16'h0000, flash_sr, 2'b00, refused, blk_efail, blk_lock,
                                         blk_valid, done_flag, (state != FSQR_S_IDLE) | eng_busy};
        `FSQR_REG_CTRL:   next_hrdata = {16'h0000, ctrl[15:0]};
        default:          next_hrdata = 32'h0000_0000;
      endcase
    end
    if (wr_pend) begin
      case (wr_addr)
        `FSQR_REG_ADDR:  next_addr = hwdata[20:0];
        `FSQR_REG_WDATA: next_wdata = hwdata[15:0];
        `FSQR_REG_CTRL:  next_ctrl = {16'h0000, hwdata[15:8], 6'h00, hwdata[1:0]};
        default: ;
      endcase
    end
  end

  // Operation sequencer
  always_comb begin
    next_state     = state;
    next_op        = op;
    next_start     = 1'b0;
    next_req       = req;
    next_rdata_q   = rdata_q;
    next_flash_sr  = flash_sr;
    next_done_flag = done_flag;
    next_refused   = refused;
    next_blk_valid = blk_valid;
    next_blk_lock  = blk_lock;
    next_blk_efail = blk_efail;
    // Write-one clears; a completing operation below sets again
    if (wr_pend && wr_addr == `FSQR_REG_STATUS) begin
      if (hwdata[`FSQR_ST_DONE]) next_done_flag = 1'b0;
      if (hwdata[`FSQR_ST_REFUSED]) next_refused = 1'b0;
    end
    case (state)
      FSQR_S_IDLE: begin
        if (cmd_write) begin
          if (!run || hwdata[2:0] == 3'd7) begin
            next_refused = 1'b1;
          end else begin
            next_op        = fsqr_pkg::fsqr_op_e'(hwdata[2:0]);
            next_start     = 1'b1;
            next_blk_valid = 1'b0;
            case (fsqr_pkg::fsqr_op_e'(hwdata[2:0]))
              fsqr_pkg::FSQR_OP_READ: begin
                next_state = FSQR_S_RD;
                next_req   = '{1'b0, byte_mode, addr, 16'h0000};
              end
              fsqr_pkg::FSQR_OP_WRITE: begin
                next_state = FSQR_S_CMD;
                next_req   = '{1'b1, byte_mode, addr, wdata};
              end
              fsqr_pkg::FSQR_OP_BLOCK: begin
                // Ready flag is checked before block status is trusted
                next_state = FSQR_S_PRE;
                next_req   = '{1'b1, byte_mode, addr, {8'h00, status_code}};
              end
              fsqr_pkg::FSQR_OP_CLEAR: begin
                // Clear only when idle; a busy device would ignore it anyway
                next_state = FSQR_S_PRE;
                next_req   = '{1'b1, byte_mode, addr, {8'h00, status_code}};
              end
              default: begin
                // Status and extended status are reissued every time to refresh the latch
                next_state = FSQR_S_CMD;
                next_req   = '{1'b1, byte_mode, addr, 16'h0000};
                next_req.data = {8'h00, (hwdata[2:0] == 3'd2) ? status_code :
                                        (hwdata[2:0] == 3'd6) ? `FSQR_CMD_MULTI : `FSQR_CMD_QUERY};
              end
            endcase
          end
        end
      end
      FSQR_S_PRE: begin
        if (eng_done) begin
          next_state = FSQR_S_PRE_RD;
          next_start = 1'b1;
          next_req   = '{1'b0, byte_mode, addr, 16'h0000};
        end
      end
      FSQR_S_PRE_RD: begin
        if (eng_done) begin
          next_flash_sr = eng_rdata[7:0];
          if (!eng_rdata[`FSQR_SR_READY]) begin
            next_state = FSQR_S_DONE;
          end else begin
            next_state = FSQR_S_CMD;
            next_start = 1'b1;
            next_req   = '{1'b1, byte_mode, addr, {8'h00, cmd_code}};
          end
        end
      end
      FSQR_S_CMD: begin
        if (eng_done) begin
          if (op == fsqr_pkg::FSQR_OP_WRITE || op == fsqr_pkg::FSQR_OP_CLEAR) begin
            next_state = FSQR_S_DONE;
          end else begin
            next_state = FSQR_S_RD;
            next_start = 1'b1;
            next_req   = '{1'b0, byte_mode, addr, 16'h0000};
            if (op == fsqr_pkg::FSQR_OP_QUERY) next_req.addr = query_addr;
            if (op == fsqr_pkg::FSQR_OP_BLOCK) next_req.addr = block_addr;
          end
        end
      end
      FSQR_S_RD: begin
        if (eng_done) begin
          next_state   = FSQR_S_DONE;
          next_rdata_q = eng_rdata;
          if (op == fsqr_pkg::FSQR_OP_QUERY || op == fsqr_pkg::FSQR_OP_BLOCK)
            next_rdata_q = {8'h00, eng_rdata[7:0]};
          if (op == fsqr_pkg::FSQR_OP_STATUS)
            next_flash_sr = eng_rdata[7:0];
          if (op == fsqr_pkg::FSQR_OP_BLOCK) begin
            next_blk_valid = 1'b1;
            next_blk_lock  = eng_rdata[`FSQR_BLK_LOCK];
            next_blk_efail = eng_rdata[`FSQR_BLK_EFAIL];
          end
        end
      end
      FSQR_S_DONE: begin
        next_done_flag = 1'b1;
        next_state     = FSQR_S_IDLE;
      end
      default: next_state = FSQR_S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      ctrl      <= `FSQR_CTRL_RST;
      addr      <= 21'h00_0000;
      wdata     <= 16'h0000;
      rdata_q   <= 16'h0000;
      flash_sr  <= 8'h00;
      done_flag <= 1'b0;
      refused   <= 1'b0;
      blk_valid <= 1'b0;
      blk_lock  <= 1'b0;
      blk_efail <= 1'b0;
      state     <= FSQR_S_IDLE;
      op        <= fsqr_pkg::FSQR_OP_WRITE;
      start     <= 1'b0;
      req       <= '0;
    end else begin
      wr_pend   <= next_wr_pend;
      wr_addr   <= next_wr_addr;
      hrdata    <= next_hrdata;
      ctrl      <= next_ctrl;
      addr      <= next_addr;
      wdata     <= next_wdata;
      rdata_q   <= next_rdata_q;
      flash_sr  <= next_flash_sr;
      done_flag <= next_done_flag;
      refused   <= next_refused;
      blk_valid <= next_blk_valid;
      blk_lock  <= next_blk_lock;
      blk_efail <= next_blk_efail;
      state     <= next_state;
      op        <= next_op;
      start     <= next_start;
      req       <= next_req;
    end
  end

  fsqr_cycle u_cycle (
    .core_clk (core_clk),
    .reset    (reset),
    .start    (start),
    .req      (req),
    .busy     (eng_busy),
    .done     (eng_done),
    .rdata    (eng_rdata),
    .dq_in    (dq_in),
    .bus      (eng_bus)
  );

endmodule : fsqr_ctrl

// ===== rtl/fsqr_cfg.svh
// Offsets, field positions, reset values and timing counts of the flash query controller
`ifndef FSQR_CFG_SVH
`define FSQR_CFG_SVH

// Controller register offsets (byte addresses, one word each)
`define FSQR_REG_CMD      8'h00
`define FSQR_REG_ADDR     8'h04
`define FSQR_REG_WDATA    8'h08
`define FSQR_REG_RDATA    8'h0C
`define FSQR_REG_STATUS   8'h10
`define FSQR_REG_CTRL     8'h14

// Status register fields
`define FSQR_ST_BUSY      0
`define FSQR_ST_DONE      1
`define FSQR_ST_BLK_VALID 2
`define FSQR_ST_BLK_LOCK  3
`define FSQR_ST_BLK_EFAIL 4
`define FSQR_ST_REFUSED   5

// Control register fields and reset values
`define FSQR_CTRL_BYTE    0
`define FSQR_CTRL_RUN     1
`define FSQR_CTRL_RST     32'h0000_7000

// Flash status byte flag positions
`define FSQR_SR_READY     7
`define FSQR_SR_ERASE     5
`define FSQR_SR_WRITE     4
`define FSQR_SR_SUPPLY    3
`define FSQR_SR_LOCK      1

// Per-block status byte fields, at word offset base plus two
`define FSQR_BLK_LOCK     0
`define FSQR_BLK_EFAIL    1
`define FSQR_BLK_OFFSET   21'h00_0002

// Flash command codes
`define FSQR_CMD_CLEAR    8'h50
`define FSQR_CMD_QUERY    8'h98
`define FSQR_CMD_MULTI    8'hE8

// Bus cycle timing
`define FSQR_CLK_NS       10
`define FSQR_T_STROBE_NS  100
`define FSQR_T_HIGH_NS    50
`define FSQR_STROBE_CYC   ((`FSQR_T_STROBE_NS + `FSQR_CLK_NS - 1) / `FSQR_CLK_NS)
`define FSQR_HIGH_CYC     ((`FSQR_T_HIGH_NS + `FSQR_CLK_NS - 1) / `FSQR_CLK_NS)

`endif

// ===== rtl/fsqr_pkg.sv
// Types shared by the flash query controller and its bus cycle engine
package fsqr_pkg;

  typedef enum logic [2:0] {
    FSQR_OP_WRITE  = 3'd0,
    FSQR_OP_READ   = 3'd1,
    FSQR_OP_STATUS = 3'd2,
    FSQR_OP_CLEAR  = 3'd3,
    FSQR_OP_QUERY  = 3'd4,
    FSQR_OP_BLOCK  = 3'd5,
    FSQR_OP_EXT    = 3'd6
  } fsqr_op_e;

  typedef struct packed {
    logic        is_write;
    logic        byte_mode;
    logic [20:0] addr;
    logic [15:0] data;
  } fsqr_req_s;

  typedef struct packed {
    logic        chip_enable0_n;
    logic        chip_enable1_n;
    logic        oe_n;
    logic        we_n;
    logic [20:0] addr;
    logic [15:0] dq_out;
    logic [15:0] dq_oe_n;
  } fsqr_bus_s;

  typedef struct packed {
    fsqr_bus_s bus;
    logic      byte_mode_n;
    logic      reset_powerdown_n;
  } fsqr_pins_s;

endpackage : fsqr_pkg

// ===== rtl/fsqr_cycle.sv
// One asynchronous flash bus cycle: setup, strobe, release and high recovery
`timescale 1ns/1ps
`include "fsqr_cfg.svh"
module fsqr_cycle (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset,
  // Request side
  input  wire logic               start,
  input  wire fsqr_pkg::fsqr_req_s req,
  output logic                    busy,
  output logic                    done,
  output logic [15:0]             rdata,
  // Flash side
  input  wire logic [15:0]        dq_in,
  output fsqr_pkg::fsqr_bus_s     bus
);

  typedef enum logic [4:0] {
    FSQR_C_IDLE   = 5'b00001,
    FSQR_C_SETUP  = 5'b00010,
    FSQR_C_STROBE = 5'b00100,
    FSQR_C_REL    = 5'b01000,
    FSQR_C_HIGH   = 5'b10000
  } fsqr_cyc_e;

  localparam logic [7:0] STROBE_LAST = 8'(`FSQR_STROBE_CYC - 1);
  localparam logic [7:0] HIGH_LAST   = 8'(`FSQR_HIGH_CYC - 1);

  fsqr_cyc_e           state, next_state;
  logic [7:0]          cnt, next_cnt;
  fsqr_pkg::fsqr_req_s cur, next_cur;
  fsqr_pkg::fsqr_bus_s next_bus;
  logic [15:0]         next_rdata;
  logic                next_done;

  assign busy = (state != FSQR_C_IDLE);

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_cur   = cur;
    next_rdata = rdata;
    next_done  = 1'b0;
    next_bus   = bus;
    case (state)
      FSQR_C_IDLE: begin
        if (start) begin
          next_cur                = req;
          next_bus.addr           = req.addr;
          next_bus.chip_enable0_n = 1'b0;
          next_bus.chip_enable1_n = 1'b0;
          next_bus.dq_out         = req.data;
          // Upper lines stay released in byte mode
          next_bus.dq_oe_n        = req.is_write ? {{8{req.byte_mode}}, 8'h00} : 16'hFFFF;
          next_state              = FSQR_C_SETUP;
        end
      end
      FSQR_C_SETUP: begin
        next_bus.we_n = ~cur.is_write;
        next_bus.oe_n = cur.is_write;
        next_cnt      = 8'h00;
        next_state    = FSQR_C_STROBE;
      end
      FSQR_C_STROBE: begin
        next_cnt = cnt + 8'h01;
        if (cnt == STROBE_LAST) begin
          next_bus.we_n = 1'b1;
          next_bus.oe_n = 1'b1;
          next_rdata    = cur.byte_mode ? {8'h00, dq_in[7:0]} : dq_in;
          next_state    = FSQR_C_REL;
        end
      end
      FSQR_C_REL: begin
        next_bus.chip_enable0_n = 1'b1;
        next_bus.chip_enable1_n = 1'b1;
        next_bus.dq_oe_n        = 16'hFFFF;
        next_cnt                = 8'h00;
        next_state              = FSQR_C_HIGH;
      end
      FSQR_C_HIGH: begin
        // Strobes held high between cycles so the next read relatches
        next_cnt = cnt + 8'h01;
        if (cnt == HIGH_LAST) begin
          next_done  = 1'b1;
          next_state = FSQR_C_IDLE;
        end
      end
      default: next_state = FSQR_C_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= FSQR_C_IDLE;
      cnt   <= 8'h00;
      cur   <= '0;
      rdata <= 16'h0000;
      done  <= 1'b0;
      bus   <= '{chip_enable0_n: 1'b1, chip_enable1_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                 addr: 21'h00_0000, dq_out: 16'h0000, dq_oe_n: 16'hFFFF};
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      cur   <= next_cur;
      rdata <= next_rdata;
      done  <= next_done;
      bus   <= next_bus;
    end
  end

endmodule : fsqr_cycle

// ===== test/fsqr_tb_pkg.sv
// Expected query database contents, shared by the flash model and the bench
package fsqr_tb_pkg;

  // Arbitrary value, stands in for the command set identity
  localparam logic [15:0] cmd_set_id = 16'h3C7E;

  function automatic logic [7:0] query_byte(input logic [19:0] woff);
    if (woff[14:0] == 15'h0002) begin
      return {6'h00, woff[16], woff[15]};
    end
    if (woff[19:8] != 12'h000) begin
      return 8'h00;
    end
    case (woff[7:0])
      8'h10: return 8'h51;
      8'h11: return 8'h52;
      8'h12: return 8'h59;
      8'h13: return cmd_set_id[15:8];
      8'h14: return cmd_set_id[7:0];
      8'h15: return 8'h31;
      8'h1B, 8'h1D: return 8'h27;
      8'h1C, 8'h1E: return 8'h55;
      8'h1F: return 8'h03;
      8'h20: return 8'h06;
      8'h21: return 8'h0A;
      8'h22: return 8'h0F;
      8'h23, 8'h24, 8'h25, 8'h26: return 8'h04;
      default: return 8'h00;
    endcase
  endfunction : query_byte

endpackage : fsqr_tb_pkg

// ===== test/fsqr_ctrl_assertions.sv
// Port-level checks of the flash query controller
`timescale 1ns/1ps
module fsqr_ctrl_assertions (
  // Clock and reset
  input wire logic                 core_clk,
  input wire logic                 reset,
  // AHB-Lite slave
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic [2:0]           hsize,
  input wire logic [31:0]          hwdata,
  input wire logic                 hready,
  input wire logic                 hreadyout,
  input wire logic [31:0]          hrdata,
  input wire logic                 hresp,
  // Flash pins
  input wire logic [15:0]          dq_in,
  input wire fsqr_pkg::fsqr_pins_s pins
);
  logic oe_n;
  logic we_n;
  assign oe_n = pins.bus.oe_n;
  assign we_n = pins.bus.we_n;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  chk_ce_paired: assert property (pins.bus.chip_enable0_n == pins.bus.chip_enable1_n)
    else $error("chip enables differ");
  chk_strobe_excl: assert property (oe_n || we_n)
    else $error("both strobes low");
  chk_strobe_ce: assert property (!(oe_n && we_n) |-> !pins.bus.chip_enable0_n)
    else $error("strobe without chip enable");
  chk_read_width: assert property ($fell(oe_n) |-> !oe_n [*8] ##1 !oe_n ##1 !oe_n ##1 oe_n)
    else $error("read strobe not ten cycles");
  chk_high_gap: assert property ($rose(oe_n) || $rose(we_n) |-> (oe_n && we_n) [*6])
    else $error("strobes not high between cycles");
  chk_read_release: assert property (!oe_n |-> pins.bus.dq_oe_n == 16'hFFFF)
    else $error("controller drives data during read");
  chk_byte_upper: assert property (!pins.byte_mode_n |-> pins.bus.dq_oe_n[15:8] == 8'hFF)
    else $error("upper lines driven in byte mode");
  chk_powered_cmd: assert property (!(oe_n && we_n) |-> pins.reset_powerdown_n)
    else $error("strobe while device powered down");
  chk_addr_hold: assert property (!oe_n && !$past(oe_n) |-> $stable(pins.bus.addr))
    else $error("address moved during read");
  chk_write_drive: assert property (!we_n |-> pins.bus.dq_oe_n[7:0] == 8'h00)
    else $error("command byte not driven");

  cover property ($fell(we_n) && pins.bus.dq_out[7:0] == 8'h98);
  cover property ($fell(we_n) && pins.bus.dq_out[7:0] == 8'h50);
  cover property ($fell(we_n) && pins.bus.dq_out[7:0] == 8'hE8);
  cover property (!oe_n && !pins.byte_mode_n);
endmodule : fsqr_ctrl_assertions

bind fsqr_ctrl fsqr_ctrl_assertions u_fsqr_chk (.core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .dq_in(dq_in), .pins(pins));

// ===== test/fsqr_flash_model.sv
// Behavioural flash device: commands, status, extended status and query data
`timescale 1ns/1ps
module fsqr_flash_model (
  // Clock
  input  wire logic                 core_clk,
  // Controller pins and the resolved data wire
  input  wire fsqr_pkg::fsqr_pins_s pins,
  input  wire logic [15:0]          dq_wire,
  // Device conditions set by the bench
  input  wire logic                 dev_busy,
  input  wire logic [7:0]           fail_set,
  // Device drive, inverse of last level when released
  output logic [15:0]               dq_drv
);
  logic [1:0]  mode = 2'd0;
  logic [7:0]  fail_flags = 8'h00;
  logic [7:0]  ext_status = 8'h00;
  logic [15:0] out_latch = 16'h0000;
  logic [15:0] last_dq = 16'h0000;
  logic        prev_rd = 1'b0;
  logic        prev_wr = 1'b0;
  logic        ce;
  logic        rd;
  logic        wr;
  logic [7:0]  sr;
  logic [15:0] en;
  logic [19:0] woff;

  assign ce = !pins.bus.chip_enable0_n && !pins.bus.chip_enable1_n;
  assign rd = ce && !pins.bus.oe_n;
  assign wr = ce && !pins.bus.we_n;
  assign woff = pins.bus.addr[20:1];
  assign sr = {!dev_busy, 7'h00} | (fail_flags & 8'h3A);
  assign en = rd ? (pins.byte_mode_n ? 16'hFFFF : 16'h00FF) : 16'h0000;
  assign dq_drv = (en & out_latch) | (~en & ~last_dq);

  always @(posedge core_clk) begin
    last_dq <= dq_wire;
    prev_rd <= rd;
    prev_wr <= wr;
    fail_flags <= fail_flags | fail_set;
    if (!pins.reset_powerdown_n) begin
      mode <= 2'd0;
    end else begin
      if (prev_wr && !wr) begin
        case (dq_wire[7:0])
          8'h70: mode <= 2'd1;
          8'hE8: begin
            mode <= 2'd2;
            ext_status <= {!dev_busy, 7'h00};
          end
          8'h98: mode <= 2'd3;
          8'h50: if (!dev_busy) fail_flags <= fail_set;
          default: mode <= 2'd0;
        endcase
      end
      // Latched once per strobe fall, so a held strobe never refreshes
      if (rd && !prev_rd) begin
        case (mode)
          2'd1: out_latch <= {8'h00, sr};
          2'd2: out_latch <= {8'h00, ext_status};
          2'd3: out_latch <= {8'h00, fsqr_tb_pkg::query_byte(woff)};
          default: out_latch <= ~woff[15:0];
        endcase
      end
    end
  end
endmodule : fsqr_flash_model

// ===== test/testbench.sv
// Self-checking bench for the flash query controller
`timescale 1ns/1ps
`include "fsqr_cfg.svh"
module testbench;
  logic                 core_clk;
  logic                 reset;
  logic                 hsel;
  logic                 hwrite;
  logic                 hready;
  logic                 hresp;
  logic                 dev_busy;
  logic [1:0]           htrans;
  logic [2:0]           hsize;
  logic [7:0]           fail_set;
  logic [7:0]           flags;
  logic [15:0]          dq_in;
  logic [15:0]          dq_drv;
  logic [19:0]          woff;
  logic [31:0]          haddr;
  logic [31:0]          hwdata;
  logic [31:0]          hrdata;
  logic [31:0]          rd;
  logic [31:0]          st;
  fsqr_pkg::fsqr_pins_s pins;
  int                   num_errors = 0;
  int                   checks_done = 0;
  int                   cycles = 0;
  integer               seed = 32'ha27125e3;

  fsqr_ctrl dut (.core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hrdata(hrdata), .hresp(hresp), .dq_in(dq_in), .pins(pins));
  fsqr_flash_model u_flash (.core_clk(core_clk), .pins(pins), .dq_wire(dq_in), .dev_busy(dev_busy),
    .fail_set(fail_set), .dq_drv(dq_drv));
  assign dq_in = (~pins.bus.dq_oe_n & pins.bus.dq_out) | (pins.bus.dq_oe_n & dq_drv);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      num_errors = num_errors + 1;
      print_verdict();
    end
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdv);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    rdv = hrdata;
  endtask : ahb

  // Polls done or refused, then clears both so the next op starts clean
  task automatic run_op(input fsqr_pkg::fsqr_op_e op, input logic [20:0] a, output logic [31:0] rdv,
                        output logic [31:0] stv);
    logic [31:0] d;
    ahb(1'b1, `FSQR_REG_ADDR, {11'h000, a}, d);
    ahb(1'b1, `FSQR_REG_CMD, {29'h0000_0000, op}, d);
    stv = 32'h0000_0000;
    // No poll limit: a hung operation is caught by the cycle ceiling
    while (stv[1] !== 1'b1 && stv[5] !== 1'b1) begin
      ahb(1'b0, `FSQR_REG_STATUS, 32'h0000_0000, stv);
    end
    ahb(1'b0, `FSQR_REG_RDATA, 32'h0000_0000, rdv);
    ahb(1'b1, `FSQR_REG_STATUS, 32'h0000_0022, d);
  endtask : run_op

  task automatic pulse_fail(input logic [7:0] f);
    @(posedge core_clk);
    fail_set <= f;
    @(posedge core_clk);
    fail_set <= 8'h00;
  endtask : pulse_fail

  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    dev_busy = 1'b0;
    fail_set = 8'h00;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    ahb(1'b0, `FSQR_REG_CTRL, 32'h0000_0000, rd);
    check_val(rd, `FSQR_CTRL_RST);
    ahb(1'b0, 8'h20, 32'h0000_0000, rd);
    run_op(fsqr_pkg::FSQR_OP_QUERY, 21'h00_0010, rd, st);
    check_val(st & 32'h0000_0020, 32'h0000_0020);
    ahb(1'b1, `FSQR_REG_CTRL, 32'h0000_7002, rd);
    flags = (8'($random(seed)) & 8'h3A) | 8'h02;
    pulse_fail(flags);
    pulse_fail(8'h10);
    flags = flags | 8'h90;
    run_op(fsqr_pkg::FSQR_OP_STATUS, 21'h00_0000, rd, st);
    check_val(rd, {24'h00_0000, flags});
    check_val({24'h00_0000, st[15:8]}, {24'h00_0000, flags});
    run_op(fsqr_pkg::FSQR_OP_READ, 21'($random(seed)) & 21'h0F_FFFF, rd, st);
    check_val(rd, {24'h00_0000, flags});
    dev_busy <= 1'b1;
    run_op(fsqr_pkg::FSQR_OP_CLEAR, 21'h00_0000, rd, st);
    dev_busy <= 1'b0;
    run_op(fsqr_pkg::FSQR_OP_STATUS, 21'h00_0000, rd, st);
    check_val(rd, {24'h00_0000, flags});
    run_op(fsqr_pkg::FSQR_OP_CLEAR, 21'h00_0000, rd, st);
    run_op(fsqr_pkg::FSQR_OP_STATUS, 21'h00_0000, rd, st);
    check_val(rd, 32'h0000_0080);
    run_op(fsqr_pkg::FSQR_OP_EXT, 21'h00_0000, rd, st);
    check_val(rd, 32'h0000_0080);
    dev_busy <= 1'b1;
    run_op(fsqr_pkg::FSQR_OP_READ, 21'h00_0004, rd, st);
    check_val(rd, 32'h0000_0080);
    run_op(fsqr_pkg::FSQR_OP_EXT, 21'h00_0000, rd, st);
    check_val(rd, 32'h0000_0000);
    run_op(fsqr_pkg::FSQR_OP_BLOCK, 21'h01_8000, rd, st);
    check_val({31'h0000_0000, st[2]}, 32'h0000_0000);
    dev_busy <= 1'b0;
    // Plain write op leaves status mode; model array reads back the inverted word offset
    ahb(1'b1, `FSQR_REG_WDATA, 32'h0000_00FF, rd);
    run_op(fsqr_pkg::FSQR_OP_WRITE, 21'h00_0000, rd, st);
    run_op(fsqr_pkg::FSQR_OP_READ, 21'h00_0123, rd, st);
    check_val(rd, 32'h0000_FF6E);
    for (int m = 0; m < 2; m++) begin
      ahb(1'b1, `FSQR_REG_CTRL, 32'h0000_7002 | m, rd);
      for (int i = 0; i < 40; i++) begin
        woff = (i < 23) ? 20'(20'h0_0010 + i) : 20'($random(seed)) & 20'h0_003F;
        run_op(fsqr_pkg::FSQR_OP_QUERY, {1'b0, woff}, rd, st);
        check_val(rd, {24'h00_0000, fsqr_tb_pkg::query_byte(woff)});
      end
    end
    for (int i = 0; i < 6; i++) begin
      woff = {5'($random(seed)), 15'h0000};
      run_op(fsqr_pkg::FSQR_OP_BLOCK, {1'b0, woff}, rd, st);
      check_val({29'h0000_0000, st[4:2]}, {29'h0000_0000, woff[16], woff[15], 1'b1});
    end
    print_verdict();
  end
endmodule : testbench
